// ==== fdc_host_defs.svh ====
// constants of the host command port of the disk controller
// Notes on behaviour
// [R1] select low reads status; select high reads the data byte.
// [R2] host never writes status nor strobes read and write together.
// [R3] 8-bit read-only status readable at any time, any phase.
// [R4] status bits 0 to 3 follow each drive's seek mode.
// [R5] busy bit set while a command is in progress.
// [R6] programmed-I/O bit set only in non-DMA execution, cleared at its end.
// [R7] bit 7 says byte slot ready; bit 6 high means toward host.
// [R8] ready flag held low for a fixed time after each data access.
// [R9] command phase: host polls status, writes when dir 0, ready 1.
// [R10] result phase: host polls status, reads when dir 1, ready 1.
// [R11] no status polling needed or relied on during execution.
// [R12] non-DMA execution raises interrupt for each byte ready.
// [R13] read strobe, or write strobe for writes, clears that interrupt.
// [R14] slow host may poll ready bit in place of the interrupt.
// [R15] transfers continue until terminal count; host drives it without DMA.
// [R16] DMA execution raises no interrupt, requests DMA per byte.
// [R17] DMA controller answers with grant low plus read or write strobe.
// [R18] DMA request drops once grant goes low.
// [R19] interrupt marks result phase, cleared by first result byte read; the code raises it only when results follow execution.
// [R20] all result bytes must be read before a new command.
// [R21] secondary status only readable as result bytes.
// [R22] host sends command code first, never shortens sequences.
// [R23] execution starts after last command byte, ends after last result.
// [R24] execution start sets direction 1 and ready 0; the code sets direction 0 for write-type commands.
// [R25] terminal count aborts any command in progress.
// [R26] reset returns to idle, keeps engine timing settings.
// [R27] strobes, grant and terminal count synchronised, acted on once.
`ifndef FDC_HOST_DEFS_SVH
`define FDC_HOST_DEFS_SVH

`define FDC_CLK_NS       20
`define FDC_READY_HOLD_NS  12000
`define FDC_READY_HOLD_CYC \
   ((`FDC_READY_HOLD_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_HOLD_W       10

`define FDC_SEL_STATUS   1'b0
`define FDC_SEL_DATA     1'b1

`define FDC_SYNC_RST     4'h7
`define FDC_SYNC_RD      0
`define FDC_SYNC_WR      1
`define FDC_SYNC_GRANT   2
`define FDC_SYNC_TC      3

`define FDC_BYTE_RST     8'h00
`define FDC_STATUS_RST   8'h00

`endif

// ==== fdc_host_pkg.sv ====
// types shared by the host command port of the disk controller
package fdc_host_pkg;

   // host bus pins sampled as one group
   typedef struct packed {
      logic       chipSelectN;
      logic       readN;
      logic       writeN;
      logic       registerSelect;
      logic [7:0] data;
   } host_bus_t;

   // main status register layout, bit 7 first
   typedef struct packed {
      logic       hostRequestFlag;
      logic       directionToHost;
      logic       programmedIoExecFlag;
      logic       controllerBusyFlag;
      logic [3:0] driveSeekFlags;
   } main_status_t;

   // command phases, one-hot
   typedef enum logic [2:0] {
      PH_CMD  = 3'b001,
      PH_EXEC = 3'b010,
      PH_RES  = 3'b100
   } phase_t;

endpackage

// ==== fdc_host_command_port.sv ====
// host side command, execution and result handshake of the disk controller
`timescale 1ns/1ps
`include "fdc_host_defs.svh"

// sits between the host bus and the disk engine with one byte slot;
// command length decoding and drive pins belong to the engine
module fdc_host_command_port
   import fdc_host_pkg::*;
(
   input  wire logic      core_clk,        // 50 MHz clock
   input  wire logic      rst,             // sync reset, high
   input  wire host_bus_t hostBus,         // host bus pins
   input  wire logic      dmaGrantN,       // DMA acknowledge, low
   input  wire logic      terminalCountIn, // terminal count, high
   output logic [7:0]     dbOut,           // data bus out
   output logic           dbOe,            // data bus drive enable
   output logic           intOut,          // interrupt to host
   output logic           dmaRequestOut,   // DMA request
   input  wire logic [3:0] driveSeek,      // drives in seek mode
   input  wire logic      execStartIn,     // engine: execution begins
   input  wire logic      execDmaIn,       // engine: DMA mode
   input  wire logic      execToHostIn,    // engine: read-type command
   input  wire logic      srcValidIn,      // engine: byte offered
   input  wire logic [7:0] srcByteIn,      // engine: offered byte
   input  wire logic      sinkReadyIn,     // engine: wants a host byte
   input  wire logic      resStartIn,      // engine: result phase begins
   input  wire logic      resLastIn,       // engine: offered byte is last
   output logic [7:0]     byteOut,         // byte from host to engine
   output logic           byteStrobe,      // byteOut valid pulse
   output logic           srcTake,         // offered byte taken pulse
   output logic           tcPulse          // terminal count seen pulse
);

   // input synchronisers and the edges taken from them
   logic [3:0]             sync1_q;
   logic [3:0]             sync2_q;
   logic [3:0]             sync3_q;
   logic                   rdFall;
   logic                   wrFall;
   logic                   grantFall;
   logic                   tcRise;

   // access decode and phase decode
   logic                   dmaCycle;
   logic                   dataSel;
   logic                   rdEv;
   logic                   wrEv;
   logic                   inCmd;
   logic                   inExec;
   logic                   inRes;

   // phase state and what the engine said at execution start
   phase_t                 phase_q;
   logic                   cmdActive_q;
   logic                   execDma_q;
   logic                   toHost_q;
   logic                   tcSeen_q;

   // the single byte slot between host and engine
   logic                   full_q;
   logic                   lastLoaded_q;
   logic [7:0]             dataReg_q;
   logic                   loadSrc;
   logic                   openSink;

   // ready flag hold-off counter
   logic [`FDC_HOLD_W-1:0] hold_q;
   logic                   holdDone;

   // main status, built each cycle and registered
   main_status_t           status_q;
   main_status_t           status_d;

   // output flip-flops
   logic [7:0]             dbOut_q;
   logic                   dbOe_q;
   logic                   int_q;
   logic                   dmaReq_q;
   logic [7:0]             byteOut_q;
   logic                   byteStrobe_q;
   logic                   srcTake_q;
   logic                   tcPulse_q;

   // three stages: first two synchronise, third gives edges
   // costs two cycles on every strobe, but a strobe held low
   // for many cycles is then acted on exactly once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_q <= `FDC_SYNC_RST;
         sync2_q <= `FDC_SYNC_RST;
         sync3_q <= `FDC_SYNC_RST;
      end else begin
         sync1_q <= {terminalCountIn, dmaGrantN,
                     hostBus.writeN, hostBus.readN}; // R27
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // edges only, so a long strobe counts once
   // stage three resets to the idle levels, so no false edge
   assign rdFall    = ~sync2_q[`FDC_SYNC_RD] & sync3_q[`FDC_SYNC_RD];
   assign wrFall    = ~sync2_q[`FDC_SYNC_WR] & sync3_q[`FDC_SYNC_WR];
   assign grantFall = ~sync2_q[`FDC_SYNC_GRANT]
                    &  sync3_q[`FDC_SYNC_GRANT];
   assign tcRise    =  sync2_q[`FDC_SYNC_TC] & ~sync3_q[`FDC_SYNC_TC];

   // DMA cycles reach the data register without chip select
   // chip select is not looked at while the grant is low
   assign dmaCycle = ~sync2_q[`FDC_SYNC_GRANT]; // R17
   assign dataSel  = dmaCycle | (~hostBus.chipSelectN
                   & (hostBus.registerSelect == `FDC_SEL_DATA)); // R1
   // a status write is ignored; the host must not issue one
   assign rdEv = rdFall & dataSel;
   assign wrEv = wrFall & dataSel; // R2

   // one-hot phase decodes shared by the processes below
   assign inCmd  = (phase_q == PH_CMD);
   assign inExec = (phase_q == PH_EXEC);
   assign inRes  = (phase_q == PH_RES);

   // byte slot fill conditions toward host and from host
   // srcTake_q blocks a refill while the old offer still shows
   assign loadSrc  = ~full_q & srcValidIn & ~srcTake_q
                   & ((inExec & toHost_q & ~tcSeen_q)
                   | (inRes & ~lastLoaded_q));
   // a write slot opens only once the previous byte has left
   assign openSink = ~full_q & sinkReadyIn & ~byteStrobe_q
                   & inExec & ~toHost_q & ~tcSeen_q;

   // phase sequencing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_q     <= PH_CMD; // R26
         cmdActive_q <= 1'b0;
         execDma_q   <= 1'b0;
         toHost_q    <= 1'b0;
         tcSeen_q    <= 1'b0;
      end else begin
         case (phase_q)
            // command bytes until the engine starts or answers
            PH_CMD: begin
               if (wrEv) begin
                  cmdActive_q <= 1'b1;
               end
               if (execStartIn) begin
                  phase_q     <= PH_EXEC; // R23
                  cmdActive_q <= 1'b0;
                  execDma_q   <= execDmaIn;
                  toHost_q    <= execToHostIn;
                  tcSeen_q    <= 1'b0;
               end else if (resStartIn) begin
                  phase_q     <= PH_RES;
                  cmdActive_q <= 1'b0;
               end
            end
            // data moves until the engine turns to the results
            PH_EXEC: begin
               if (tcRise) begin
                  tcSeen_q <= 1'b1; // R15
               end
               if (resStartIn) begin
                  phase_q <= PH_RES;
               end
            end
            PH_RES: begin
               // new commands stay locked out until the last byte
               if (rdEv & full_q & lastLoaded_q) begin
                  phase_q <= PH_CMD; // R20 R23
               end
            end
            default: begin
               phase_q <= PH_CMD;
            end
         endcase
      end
   end

   // terminal count goes to the engine in any phase once a command byte has arrived, it aborts
   // the engine decides what an abort means for the drive
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tcPulse_q <= 1'b0;
      end else begin
         tcPulse_q <= tcRise & (cmdActive_q | ~inCmd); // R25
      end
   end

   // byte slot: holds a byte for the host, or awaits one from it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         full_q       <= 1'b0;
         lastLoaded_q <= 1'b0;
         dataReg_q    <= `FDC_BYTE_RST;
         srcTake_q    <= 1'b0;
      end else begin
         // the engine must drop its offer the cycle after srcTake
         srcTake_q <= 1'b0;
         // a phase change empties the slot, stale bytes never leak
         if (inCmd | resStartIn | execStartIn) begin
            full_q       <= 1'b0;
            lastLoaded_q <= 1'b0;
         end else if (loadSrc) begin
            dataReg_q    <= srcByteIn; // R21
            full_q       <= 1'b1;
            srcTake_q    <= 1'b1;
            lastLoaded_q <= (phase_q == PH_RES) & resLastIn;
         end else if (openSink) begin
            full_q <= 1'b1;
         end else if (full_q & (rdEv | wrEv)) begin
            full_q <= 1'b0; // R13
         end
      end
   end

   // host bytes go to the engine: command bytes and write data
   // a write with no open slot is dropped without a sign
   always_ff @(posedge core_clk) begin
      if (rst) begin
         byteOut_q    <= `FDC_BYTE_RST;
         byteStrobe_q <= 1'b0;
      end else begin
         byteStrobe_q <= 1'b0;
         if (wrEv & ((phase_q == PH_CMD)
             | ((phase_q == PH_EXEC) & ~toHost_q & full_q))) begin
            byteOut_q    <= hostBus.data;
            byteStrobe_q <= 1'b1;
         end
      end
   end

   // ready flag hold-off after every data register access
   // count rounds up, so the flag never returns early;
   // an access during a running hold restarts it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_q <= '0;
      end else if (rdEv | wrEv) begin
         hold_q <= `FDC_HOLD_W'(`FDC_READY_HOLD_CYC); // R8
      end else if (!holdDone) begin
         hold_q <= hold_q - `FDC_HOLD_W'(1);
      end
   end
   assign holdDone = (hold_q == '0);

   // interrupt: per byte without DMA, and at result start after execution
   // set wins over the clearing strobe, so no byte goes unflagged
   always_ff @(posedge core_clk) begin
      if (rst) begin
         int_q <= 1'b0;
      end else if ((phase_q == PH_EXEC) & ~execDma_q
                   & (loadSrc | openSink)) begin
         int_q <= 1'b1; // R12 R16
      end else if ((phase_q == PH_EXEC) & resStartIn) begin
         int_q <= 1'b1; // R19
      end else if (rdEv | wrEv) begin
         int_q <= 1'b0; // R13 R19
      end
   end

   // DMA request per byte; the grant edge takes it down
   // a new byte in the grant cycle wins, it is a real request;
   // leaving execution drops any request left standing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dmaReq_q <= 1'b0;
      end else if (inExec & execDma_q & (loadSrc | openSink)) begin
         dmaReq_q <= 1'b1; // R16
      end else if (grantFall | ~inExec) begin
         dmaReq_q <= 1'b0; // R18
      end
   end

   // status bits recomputed every cycle, no host read needed
   always_comb begin
      status_d                      = `FDC_STATUS_RST;
      status_d.driveSeekFlags       = driveSeek; // R4
      status_d.controllerBusyFlag   = cmdActive_q
                                    | (phase_q != PH_CMD); // R5
      status_d.programmedIoExecFlag = (phase_q == PH_EXEC)
                                    & ~execDma_q; // R6

      // direction and ready depend on the phase
      case (phase_q)
         PH_CMD: begin
            status_d.directionToHost = 1'b0; // R7
            status_d.hostRequestFlag = holdDone; // R9
         end
         PH_EXEC: begin
            // without DMA the flag mirrors the per-byte interrupt
            status_d.directionToHost = toHost_q; // R24
            status_d.hostRequestFlag = ~execDma_q & full_q
                                     & holdDone; // R14 R11
         end
         PH_RES: begin
            // results always flow toward the host
            status_d.directionToHost = 1'b1;
            status_d.hostRequestFlag = full_q & holdDone; // R10
         end
         default: begin
            status_d.directionToHost = 1'b0;
            status_d.hostRequestFlag = 1'b0;
         end
      endcase
   end

   // registered so the bus never shows a half-built status
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_q <= `FDC_STATUS_RST;
      end else begin
         status_q <= status_d; // R3
      end
   end

   // bus read path; the enable follows the synchronised read strobe
   // status on the bus is two cycles old but always settled
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dbOut_q <= `FDC_BYTE_RST;
         dbOe_q  <= 1'b0;
      end else begin
         dbOe_q <= ~sync2_q[`FDC_SYNC_RD]
                 & (dmaCycle | ~hostBus.chipSelectN);
         if (dataSel) begin
            dbOut_q <= dataReg_q; // R1 R13
         end else begin
            dbOut_q <= status_q; // R1 R3
         end
      end
   end

   // every output straight from its flip-flop
   assign dbOut         = dbOut_q;
   assign dbOe          = dbOe_q;
   assign intOut        = int_q;
   assign dmaRequestOut = dmaReq_q;
   assign byteOut       = byteOut_q;
   assign byteStrobe    = byteStrobe_q;
   assign srcTake       = srcTake_q;
   assign tcPulse       = tcPulse_q;

endmodule

// ==== fdc_host_command_port_checker.sv ====
// assertions on the host port of the disk controller
`timescale 1ns/1ps
module fdc_host_command_port_checker
   import fdc_host_pkg::*;
(
   input wire logic       core_clk,        // clock
   input wire logic       rst,             // sync reset
   input wire host_bus_t  hostBus,         // host pins
   input wire logic       dmaGrantN,       // grant, low
   input wire logic       terminalCountIn, // tc in
   input wire logic [7:0] dbOut,           // read data
   input wire logic       dbOe,            // read drive
   input wire logic       intOut,          // interrupt
   input wire logic       dmaRequestOut,   // dma request
   input wire logic [3:0] driveSeek,       // seek modes
   input wire logic       execStartIn,     // exec begins
   input wire logic       execDmaIn,       // dma mode
   input wire logic       resStartIn,      // result begins
   input wire logic [7:0] byteOut,         // host byte
   input wire logic       byteStrobe,      // host byte valid
   input wire logic       tcPulse          // tc seen
);
   logic dmaMode_q; // execution runs under dma

   // mode is only visible at the start pulse, so keep it here
   always_ff @(posedge core_clk) begin
      if (rst || resStartIn) dmaMode_q <= 1'b0;
      else if (execStartIn) dmaMode_q <= execDmaIn;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence rdData;
      $fell(hostBus.readN) && !hostBus.chipSelectN;
   endsequence
   sequence rdIdle;
      hostBus.readN [*5];
   endsequence

   AST_RD_OE: assert property (rdData |-> ##[2:4] dbOe)
      else $error("read drive late");
   AST_OE_OFF: assert property (rdIdle |-> !dbOe)
      else $error("read drive held");
   AST_SEEK: assert property (dbOe && !hostBus.registerSelect
      && driveSeek == $past(driveSeek, 4) |-> dbOut[3:0] == driveSeek)
      else $error("seek bits wrong");
   AST_DMA_NOINT: assert property (dmaMode_q |-> !intOut)
      else $error("interrupt in dma");
   AST_INT_CLR: assert property (rdData ##0
      (hostBus.registerSelect && intOut) |-> ##[2:4] !intOut)
      else $error("interrupt not cleared");
   AST_REQ_DROP: assert property ($fell(dmaGrantN)
      |-> ##[1:4] !dmaRequestOut)
      else $error("request not dropped");
   AST_TC_PULSE: assert property (tcPulse
      |-> $past(terminalCountIn, 2) && !$past(tcPulse))
      else $error("tc pulse wrong");
   AST_STROBE_BYTE: assert property (byteStrobe
      |-> byteOut == $past(hostBus.data) && !$past(hostBus.writeN, 2))
      else $error("host byte wrong");
endmodule

bind fdc_host_command_port fdc_host_command_port_checker chk (
   .core_clk, .rst, .hostBus, .dmaGrantN, .terminalCountIn, .dbOut,
   .dbOe, .intOut, .dmaRequestOut, .driveSeek, .execStartIn, .execDmaIn,
   .resStartIn, .byteOut, .byteStrobe, .tcPulse
);

// ==== fdc_host_model.sv ====
// host processor and dma controller model on the port pins
`timescale 1ns/1ps
module fdc_host_model
   import fdc_host_pkg::*;
(
   input  wire logic       core_clk,  // clock
   input  wire logic [7:0] dbOut,     // read data
   output host_bus_t       hostBus,   // host pins
   output logic            dmaGrantN  // grant, low
);
   // idle bus at time zero
   initial begin
      hostBus = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
      dmaGrantN = 1'b1;
   end

   // one access; strobes 5 cycles low, 4 high, as the port needs
   task automatic acc(input logic rs, wr, dma, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge core_clk);
      hostBus.chipSelectN <= dma;
      hostBus.registerSelect <= rs;
      hostBus.data <= wr ? d : ~hostBus.data;
      dmaGrantN <= !dma;
      hostBus.readN <= wr;
      hostBus.writeN <= !wr;
      repeat (5) @(posedge core_clk);
      q = dbOut;
      hostBus.readN <= 1'b1;
      hostBus.writeN <= 1'b1;
      dmaGrantN <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

// ==== fdc_host_command_port_tb_top.sv ====
// self-checking bench for the host command port
`timescale 1ns/1ps
module fdc_host_command_port_tb_top
   import fdc_host_pkg::*;
;
   logic       core_clk, rst, terminalCountIn, execStartIn, execDmaIn;
   logic       execToHostIn, srcValidIn, sinkReadyIn, resStartIn;
   logic       resLastIn, dmaGrantN, dbOe, intOut, dmaRequestOut;
   logic       byteStrobe, srcTake, tcPulse;
   logic [7:0] dbOut, srcByteIn, byteOut, got, q, b;
   logic [3:0] driveSeek;
   host_bus_t  hostBus;
   int         nFail = 0;
   int         checkCount = 0;
   int         n;

   fdc_host_command_port dut (.core_clk, .rst, .hostBus, .dmaGrantN,
      .terminalCountIn, .dbOut, .dbOe, .intOut, .dmaRequestOut,
      .driveSeek, .execStartIn, .execDmaIn, .execToHostIn, .srcValidIn,
      .srcByteIn, .sinkReadyIn, .resStartIn, .resLastIn, .byteOut,
      .byteStrobe, .srcTake, .tcPulse);
   fdc_host_model host (.core_clk, .dbOut, .hostBus, .dmaGrantN);

   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // engine side keeps the last byte handed over
   always @(posedge core_clk) if (byteStrobe === 1'b1) got <= byteOut;

   task automatic chk(input string nm, input logic [7:0] s, e);
      checkCount++;
      if (s !== e) begin
         nFail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [7:0] st(input logic [3:0] f);
      return {f, driveSeek};
   endfunction

   task automatic rdSt(input logic [3:0] f, input string nm);
      host.acc(1'b0, 1'b0, 1'b0, 8'h00, q);
      chk(nm, q, st(f));
   endtask

   // engine offers a byte until the port takes it
   task automatic offer(input logic [7:0] v, input logic last);
      srcByteIn <= v;
      resLastIn <= last;
      srcValidIn <= 1'b1;
      n = 0;
      do @(posedge core_clk); while (srcTake !== 1'b1 && ++n < 40);
      srcValidIn <= 1'b0;
   endtask

   task automatic conclude();
      if (nFail == 0 && checkCount > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // cut a hang short well past the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      nFail++;
      conclude();
   end

   // main sequence: command, non-dma read, result, dma write
   initial begin
      {execStartIn, execDmaIn, execToHostIn, srcValidIn} = '0;
      {sinkReadyIn, resStartIn, resLastIn, terminalCountIn} = '0;
      srcByteIn = '0;
      rst = 1'b1;
      void'($urandom(32'h28890CD3));
      driveSeek = 4'($urandom);
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      rdSt(4'h8, "status idle");
      b = 8'($urandom);
      host.acc(1'b1, 1'b1, 1'b0, b, q);
      chk("command byte", got, b);
      rdSt(4'h1, "status held");
      repeat (600) @(posedge core_clk);
      rdSt(4'h9, "status ready");
      execToHostIn <= 1'b1;
      execStartIn <= 1'b1;
      @(posedge core_clk);
      execStartIn <= 1'b0;
      rdSt(4'h7, "status exec");
      repeat (3) begin
         b = 8'($urandom);
         offer(b, 1'b0);
         @(posedge core_clk);
         chk("byte int", {7'h00, intOut}, 8'h01);
         host.acc(1'b1, 1'b0, 1'b0, 8'h00, q);
         chk("exec byte", q, b);
         chk("int clear", {7'h00, intOut}, 8'h00);
      end
      terminalCountIn <= 1'b1;
      n = 0;
      do @(posedge core_clk); while (tcPulse !== 1'b1 && ++n < 20);
      chk("tc seen", {7'h00, tcPulse}, 8'h01);
      terminalCountIn <= 1'b0;
      resStartIn <= 1'b1;
      @(posedge core_clk);
      resStartIn <= 1'b0;
      @(posedge core_clk);
      chk("result int", {7'h00, intOut}, 8'h01);
      for (int i = 0; i < 7; i++) begin
         b = 8'($urandom);
         offer(b, i == 6);
         repeat (600) @(posedge core_clk);
         rdSt(4'hD, "status result");
         host.acc(1'b1, 1'b0, 1'b0, 8'h00, q);
         chk("result byte", q, b);
         chk("result int off", {7'h00, intOut}, 8'h00);
      end
      repeat (600) @(posedge core_clk);
      rdSt(4'h8, "status done");
      execDmaIn <= 1'b1;
      execToHostIn <= 1'b0;
      execStartIn <= 1'b1;
      @(posedge core_clk);
      execStartIn <= 1'b0;
      host.acc(1'b0, 1'b0, 1'b0, 8'h00, q);
      chk("status dma", q & 8'h7F, st(4'h1));
      repeat (2) begin
         sinkReadyIn <= 1'b1;
         n = 0;
         do @(posedge core_clk); while (dmaRequestOut !== 1'b1 && ++n < 20);
         sinkReadyIn <= 1'b0;
         chk("dma request", {6'h00, intOut, dmaRequestOut}, 8'h01);
         b = 8'($urandom);
         host.acc(1'b1, 1'b1, 1'b1, b, q);
         chk("dma byte", got, b);
         chk("request off", {7'h00, dmaRequestOut}, 8'h00);
      end
      conclude();
   end
endmodule
